//--- src/vic_pkg.sv
// Purpose: constants for the interpolated oscillator control block
// Assumes: avalon-mm register access, 32-bit data, byte addresses
// Notes:   field layout of code and divider registers chosen locally
package vic_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  // register byte offsets
  localparam logic [3:0]  OFS_CONTROL   = 4'h0;
  localparam logic [3:0]  OFS_CODE      = 4'h4;
  localparam logic [3:0]  OFS_DIVIDER   = 4'h8;
  // control fields
  localparam int          RUN_BIT       = 0;
  localparam int          PREC_LO       = 1;
  localparam int          PREC_HI       = 3;
  localparam logic [2:0]  PREC_RESET    = 3'h0;
  localparam logic [4:0]  PREC_MAX_BITS = 5'h10;
  // code and divider fields
  localparam int          CODE_W        = 16;
  localparam int          DIV_W         = 16;
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [15:0] DIV_RESET     = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam logic        IDLE_LEVEL    = 1'b0;
  // bus answer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } vic_bus_t;
endpackage

//--- src/vic_interp.sv
// Purpose: single-bit interpolated control output for an external vcxo
// Assumes: one clock, async active-high reset, avalon-mm slave
// Notes:   first-order accumulator modulator; one wait state per access
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - one-bit interpolated output, resolution programmable from 9 to 16 bits
// - output stream follows latest input code; time clock is separate input
// - each input code write is used as the new code from then on
// - control at 00h, input code at 04h, divider at 08h
// - precision bits 3-1, value 0 means 16 bits down to 7h means 9
// - precision writes ignored while run bit is 1
// - run bit at bit 0, resets 0, writable any time
module vic_interp #(
  parameter int CODE_W = vic_pkg::CODE_W,
  parameter int DIV_W  = vic_pkg::DIV_W
) (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // avalon-mm slave
  input  wire logic [vic_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [vic_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [vic_pkg::DATA_W-1:0] AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  // oscillator pins
  input  wire logic                       TIME_REFERENCE_CLOCK_IN,
  output logic                            OSCILLATOR_STEER_OUT,
  output logic                            TIME_REFERENCE_CLOCK_SEEN
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: answers one cycle after the request
  vic_pkg::vic_bus_t        bus_q, bus_d;
  logic                     run_q, run_d;
  logic [2:0]               prec_q, prec_d;
  logic [CODE_W-1:0]        code_q, code_d;
  logic [DIV_W-1:0]         div_q, div_d;
  logic [vic_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic                     wr_go;

  // byte lanes overlay the current word, so a partial write keeps the rest
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // register read view; reserved and unmapped bits read as zero
  function automatic logic [31:0] read_word(input logic [vic_pkg::ADDR_W-1:0] a,
                                            input logic                       run,
                                            input logic [2:0]                 prec,
                                            input logic [CODE_W-1:0]          code,
                                            input logic [DIV_W-1:0]           div);
    logic [31:0] w;
    w = vic_pkg::UNMAPPED_READ;
    case (a)
      vic_pkg::OFS_CONTROL: begin
        w[vic_pkg::RUN_BIT]                  = run;
        w[vic_pkg::PREC_HI:vic_pkg::PREC_LO] = prec;
      end
      vic_pkg::OFS_CODE:    w = 32'(code);
      vic_pkg::OFS_DIVIDER: w = 32'(div);
      default:              w = vic_pkg::UNMAPPED_READ;
    endcase
    return w;
  endfunction

  always_comb begin
    logic [31:0] cur;
    logic [31:0] nw;
    cur     = read_word(AVS_ADDRESS, run_q, prec_q, code_q, div_q);
    nw      = merge(cur, AVS_WRITEDATA, AVS_BYTEENABLE);
    bus_d   = bus_q;
    run_d   = run_q;
    prec_d  = prec_q;
    code_d  = code_q;
    div_d   = div_q;
    rdata_d = rdata_q;
    wr_go   = 1'b0;
    case (bus_q)
      vic_pkg::BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          bus_d = vic_pkg::BUS_ACK;
        end
        // loaded now so the word stands while waitrequest is low
        if (AVS_READ) begin
          rdata_d = cur;
        end
      end
      vic_pkg::BUS_ACK: begin
        bus_d = vic_pkg::BUS_IDLE;
        wr_go = AVS_WRITE;
        if (wr_go) begin
          case (AVS_ADDRESS)
            vic_pkg::OFS_CONTROL: begin
              run_d = nw[vic_pkg::RUN_BIT];
              if (!run_q) begin
                prec_d = nw[vic_pkg::PREC_HI:vic_pkg::PREC_LO];
              end
            end
            vic_pkg::OFS_CODE:    code_d = nw[CODE_W-1:0];
            vic_pkg::OFS_DIVIDER: div_d = nw[DIV_W-1:0];
            default: ;
          endcase
        end
      end
      default: bus_d = vic_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus_q   <= vic_pkg::BUS_IDLE;
      run_q   <= 1'b0;
      prec_q  <= vic_pkg::PREC_RESET;
      code_q  <= vic_pkg::CODE_RESET;
      div_q   <= vic_pkg::DIV_RESET;
      rdata_q <= vic_pkg::UNMAPPED_READ;
    end else begin
      bus_q   <= bus_d;
      run_q   <= run_d;
      prec_q  <= prec_d;
      code_q  <= code_d;
      div_q   <= div_d;
      rdata_q <= rdata_d;
    end
  end

  // waitrequest low only in the answer cycle
  assign AVS_WAITREQUEST = (bus_q != vic_pkg::BUS_ACK);
  assign AVS_READDATA    = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // modulator: tick every div+1 cycles, accumulator of the top code bits
  logic [DIV_W-1:0]  tick_cnt_q, tick_cnt_d;
  logic [CODE_W-1:0] acc_q, acc_d;
  logic              out_q, out_d;
  logic [CODE_W-1:0] mask;
  logic              tick;

  // precision 0 keeps every code bit, each step drops one more lsb
  function automatic logic [CODE_W-1:0] precision_mask(input logic [2:0] p);
    logic [CODE_W-1:0] m;
    m = '1;
    return m << p;
  endfunction

  always_comb begin
    mask = precision_mask(prec_q);
  end

  always_comb begin
    logic [CODE_W:0] sum;
    sum        = {1'b0, acc_q} + {1'b0, code_q & mask};
    tick       = (tick_cnt_q == div_q);
    tick_cnt_d = tick_cnt_q + 1'b1;
    acc_d      = acc_q;
    out_d      = out_q;
    if (tick) begin
      tick_cnt_d = '0;
    end
    if (!run_q) begin
      tick_cnt_d = '0;
      acc_d      = '0;
      out_d      = vic_pkg::IDLE_LEVEL;
    end else if (tick) begin
      // carry out of the accumulator gives ones density (code & mask)/2^16
      acc_d = sum[CODE_W-1:0];
      out_d = sum[CODE_W];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_q <= '0;
      acc_q      <= '0;
      out_q      <= vic_pkg::IDLE_LEVEL;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      acc_q      <= acc_d;
      out_q      <= out_d;
    end
  end

  assign OSCILLATOR_STEER_OUT = out_q;

  ////////////////////////////////////////////////////////////////////////////////
  // time clock input: only synchronised and reported; the counter lives elsewhere
  // two flops: the pin runs from an unrelated oscillator
  logic sync1_q;
  logic sync2_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= TIME_REFERENCE_CLOCK_IN;
      sync2_q <= sync1_q;
    end
  end

  assign TIME_REFERENCE_CLOCK_SEEN = sync2_q;

endmodule

//--- testbench/vic_interp_monitor.sv
// Purpose: bus and output checks for vic_interp
// Assumes: all byte lanes enabled
// Notes:   shadows control, code and divider writes
`timescale 1ns/1ps
module vic_interp_monitor (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // bus and pin
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        OSCILLATOR_STEER_OUT
);
  logic        run_q;
  logic [2:0]  prec_q;
  logic [15:0] code_q, div_q;
  // precision shadow keeps old value while running
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      {run_q, prec_q, code_q, div_q} <= '0;
    end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
      if (AVS_ADDRESS == 4'h0) begin
        run_q <= AVS_WRITEDATA[0];
        if (!run_q) prec_q <= AVS_WRITEDATA[3:1];
      end
      if (AVS_ADDRESS == 4'h4) code_q <= AVS_WRITEDATA[15:0];
      if (AVS_ADDRESS == 4'h8) div_q <= AVS_WRITEDATA[15:0];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rd(logic [3:0] a); AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a; endsequence
  sequence s_answer; AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
  property p_one_wait; $rose(AVS_READ || AVS_WRITE) |-> s_answer; endproperty
  property p_ack; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  property p_ctrl; s_rd(4'h0) |-> AVS_READDATA[31:1] == {28'h0, prec_q}; endproperty
  property p_run; s_rd(4'h0) |-> AVS_READDATA[0] == run_q; endproperty
  property p_code; s_rd(4'h4) |-> AVS_READDATA == {16'h0, code_q}; endproperty
  property p_div; s_rd(4'h8) |-> AVS_READDATA == {16'h0, div_q}; endproperty
  property p_gap; s_rd(4'hC) |-> AVS_READDATA == 32'h0; endproperty
  property p_idle; !run_q ##1 !run_q |-> !OSCILLATOR_STEER_OUT; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  a_ack: assert property (p_ack) else $error("answer longer than one cycle");
  a_ctrl: assert property (p_ctrl) else $error("control field wrong");
  a_run: assert property (p_run) else $error("run bit wrong");
  a_code: assert property (p_code) else $error("code readback wrong");
  a_div: assert property (p_div) else $error("divider readback wrong");
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  a_idle: assert property (p_idle) else $error("output active while stopped");
endmodule
bind vic_interp vic_interp_monitor vic_interp_monitor_i (.CLK(CLK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .OSCILLATOR_STEER_OUT(OSCILLATOR_STEER_OUT));

//--- testbench/vic_vcxo_model.sv
// Purpose: external oscillator feeding the time clock
// Assumes: steer level pulls the period slightly
// Notes:   free running, never stops
`timescale 1ns/1ps
module vic_vcxo_model (
  input  wire logic steer,
  output logic      clk_o
);
  // separate time clock pin, unrelated to the bus clock
  initial begin
    clk_o = 1'h0;
    forever #(steer === 1'h1 ? 34 : 38) clk_o = !clk_o;
  end
endmodule

//--- testbench/vic_interp_tb_top.sv
// Purpose: register and output tests for vic_interp
// Assumes: 20 MHz clock, byte lanes tied on
// Notes:   densities judged over 400 cycles
`timescale 1ns/1ps
module vic_interp_tb_top;
  logic        clk, rst, rd, wr, wreq, time_reference_clock_in, steer, seen;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, rdv;
  int          miscompares, total_checks, cyc, ones, edges;
  vic_interp vic_interp_i (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .TIME_REFERENCE_CLOCK_IN(time_reference_clock_in),
    .OSCILLATOR_STEER_OUT(steer), .TIME_REFERENCE_CLOCK_SEEN(seen));
  vic_vcxo_model vic_vcxo_model_i (.steer(steer), .clk_o(time_reference_clock_in));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    do @(posedge clk); while (wreq !== 1'h0);
    rdv = rdata;
    {wr, rd} <= 2'h0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(n, rdv, e);
  endtask
  task automatic watch(input int n);
    ones = 0;
    repeat (n) @(negedge clk) ones += int'(steer === 1'h1);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #25 clk = !clk;
  end
  always @(posedge seen) edges++;
  // run needs about 1350 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {rst, rd, wr, addr, wdata} = {1'h1, 38'h0};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rchk("ctrl", 4'h0, 32'h0);
    rchk("code", 4'h4, 32'h0);
    rchk("div", 4'h8, 32'h0);
    acc(1'h1, 4'hC, 32'hFFFFFFFF);
    rchk("gap", 4'hC, 32'h0);
    watch(40);
    chk("idle", ones, 0);
    acc(1'h1, 4'h0, 32'h0);
    acc(1'h1, 4'h0, 32'hFFFFFFFE);
    acc(1'h1, 4'h8, 32'h3);
    acc(1'h1, 4'h0, 32'hF);
    rchk("ctrl", 4'h0, 32'hF);
    acc(1'h1, 4'h0, 32'h1);
    rchk("locked", 4'h0, 32'hF);
    // 9 bits: low seven code bits dropped
    acc(1'h1, 4'h4, 32'h7F);
    watch(400);
    chk("masked", ones, 0);
    acc(1'h1, 4'h4, 32'hC000);
    watch(400);
    chk("dens75", ones >= 292 && ones <= 308, 1);
    acc(1'h1, 4'h4, 32'h4000);
    watch(400);
    chk("dens25", ones >= 92 && ones <= 108, 1);
    acc(1'h1, 4'h0, 32'h0);
    rchk("stop", 4'h0, 32'hE);
    watch(40);
    chk("stopped", ones, 0);
    acc(1'h1, 4'h0, 32'h4);
    rchk("prec2", 4'h0, 32'h4);
    chk("timeclk", edges > 0, 1);
    results();
  end
endmodule
